/* File: rtl/pse_event_pkg.sv */
package pse_event_pkg;

    localparam int NUM_CH   = 4;
    localparam int NUM_PAIR = NUM_CH / 2;
    localparam int CLK_HZ   = 50_000_000;

    // command codes of the event registers
    localparam logic [7:0] CMD_START_LIMIT_RO  = 8'h08;
    localparam logic [7:0] CMD_START_LIMIT_CLR = 8'h09;
    localparam logic [7:0] CMD_SUPPLY_FAULT_RO = 8'h0A;
    localparam logic [7:0] CMD_SUPPLY_FAULT_CLR = 8'h0B;

    // values after reset, and the read data of unmapped codes
    localparam logic [7:0] START_LIMIT_RESET  = 8'h00;
    localparam logic [7:0] SUPPLY_FAULT_RESET = 8'h70;
    localparam logic [7:0] UNMAPPED_DATA      = 8'h00;

    // field positions of the start/limit register
    localparam int STRT_LSB = 0;
    localparam int LIM_LSB  = 4;

    // field positions of the supply and fault register
    localparam int SUP_THERMAL   = 7;
    localparam int SUP_VDD_UV    = 6;
    localparam int SUP_VDD_WARN  = 5;
    localparam int SUP_VPWR_UV   = 4;
    localparam int SUP_OVLD_34   = 3;
    localparam int SUP_OVLD_12   = 2;
    localparam int SUP_FAST_SHDN = 1;
    localparam int SUP_MEM_FAULT = 0;

    // times in milliseconds and their cycle counts
    localparam int STARTUP_TIME_MS     = 60;
    localparam int LIMIT_FAULT_TIME_MS = 60;
    localparam int COOLDOWN_TIME_MS    = 1000;
    localparam int CYC_PER_MS          = CLK_HZ / 1000;
    localparam int STARTUP_CYC         = STARTUP_TIME_MS * CYC_PER_MS;
    localparam int LIMIT_FAULT_CYC     = LIMIT_FAULT_TIME_MS * CYC_PER_MS;
    localparam int COOLDOWN_CYC        = COOLDOWN_TIME_MS * CYC_PER_MS;

    typedef enum logic [1:0] {
        CH_OFF    = 2'b00,
        CH_INRUSH = 2'b01,
        CH_ON     = 2'b11,
        CH_COOL   = 2'b10
    } chan_state_e;

    typedef struct packed {
        logic four_pair;
        logic dual_sig;
        logic class_high;
    } pair_cfg_s;

    // order matches the supply and fault register, bit 7 first
    typedef struct packed {
        logic thermal_shutdown_flag;
        logic logic_supply_undervoltage_flag;
        logic logic_supply_warning_flag;
        logic power_supply_undervoltage_flag;
        logic summed_overload_flag_ch_three_four;
        logic summed_overload_flag_ch_one_two;
        logic fast_shutdown_event_flag;
        logic program_memory_fault_flag;
    } supply_evt_s;

endpackage

/* File: rtl/pse_port_fault_event_flags.sv */
`timescale 1ns/1ps
`default_nettype none

module pse_port_fault_event_flags
    import pse_event_pkg::*;
#(
    parameter int unsigned START_CYC = STARTUP_CYC,
    parameter int unsigned LIMIT_CYC = LIMIT_FAULT_CYC,
    parameter int unsigned COOL_CYC  = COOLDOWN_CYC
) (
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  cmd_valid_i,
    input  wire logic [7:0]            cmd_code_i,
    output logic      [7:0]            rd_data_o,
    output logic                       rd_valid_o,
    input  wire logic [1:0]            int_mask_i,
    output logic                       int_n_o,
    input  wire pair_cfg_s [NUM_PAIR-1:0] pair_cfg_i,
    input  wire logic                  auto_mode_i,
    input  wire logic [NUM_CH-1:0]     power_on_command_i,
    input  wire logic [NUM_CH-1:0]     power_off_i,
    input  wire logic [NUM_CH-1:0]     inrush_fault_i,
    input  wire logic [NUM_CH-1:0]     current_limit_i,
    input  wire logic [NUM_CH-1:0]     discovery_error_i,
    input  wire supply_evt_s           supply_evt_i,
    output logic      [NUM_CH-1:0]     channel_enable_o,
    output logic      [NUM_CH-1:0]     power_good_flag_o,
    output logic      [NUM_CH-1:0]     cooldown_o
);

    chan_state_e       state      [NUM_CH];
    chan_state_e       next_state [NUM_CH];
    logic [31:0]       tmr        [NUM_CH];
    logic [31:0]       next_tmr   [NUM_CH];
    logic [31:0]       lim_cnt    [NUM_CH];
    logic [NUM_CH-1:0] lim_hit;
    logic [NUM_CH-1:0] start_set;
    logic [NUM_CH-1:0] lim_set;
    logic [7:0]        start_limit;
    logic [7:0]        supply_fault;
    logic [7:0]        next_start_limit;
    logic [7:0]        next_supply_fault;
    logic              clr_start_limit;
    logic              clr_supply_fault;

    function automatic logic [31:0] load(input int unsigned cyc);
        load = (cyc > 1) ? 32'(cyc - 1) : 32'h0000_0000;
    endfunction

    function automatic logic timer_done(input logic [31:0] t);
        timer_done = (t == 32'h0000_0000);
    endfunction

    assign clr_start_limit  = cmd_valid_i && (cmd_code_i == CMD_START_LIMIT_CLR);
    assign clr_supply_fault = cmd_valid_i && (cmd_code_i == CMD_SUPPLY_FAULT_CLR);

    // limit timer: only counts while powered and held at the limit
    always_ff @(posedge clk_i) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (srst_i || state[c] != CH_ON || !current_limit_i[c]) begin
                lim_cnt[c] <= 32'h0000_0000;
            end else if (!lim_hit[c]) begin
                lim_cnt[c] <= lim_cnt[c] + 32'h0000_0001;
            end
        end
    end

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            lim_hit[c] = (state[c] == CH_ON) && current_limit_i[c]
                         && (lim_cnt[c] >= load(LIMIT_CYC));
        end
    end

    // channel sequencing, one pair at a time
    always_comb begin
        int a;
        int b;
        logic ss;
        logic fault;
        a = 0;
        b = 0;
        ss = 1'b0;
        fault = 1'b0;
        start_set = '0;
        lim_set   = lim_hit;
        for (int c = 0; c < NUM_CH; c++) begin
            next_state[c] = state[c];
            next_tmr[c]   = timer_done(tmr[c]) ? tmr[c] : tmr[c] - 32'h0000_0001;
        end
        for (int p = 0; p < NUM_PAIR; p++) begin
            a  = 2 * p;
            b  = 2 * p + 1;
            ss = pair_cfg_i[p].four_pair && !pair_cfg_i[p].dual_sig;
            if (ss) begin
                // the pair moves as one port; the odd channel follows the even one, but joins inrush only when class_high is set
                case (state[a])
                    CH_OFF: begin
                        if (power_on_command_i[a] || power_on_command_i[b]) begin
                            next_state[a] = CH_INRUSH;
                            next_tmr[a]   = load(START_CYC);
                            if (pair_cfg_i[p].class_high) begin
                                next_state[b] = CH_INRUSH;
                                next_tmr[b]   = load(START_CYC);
                            end
                        end
                    end
                    CH_INRUSH: begin
                        if (timer_done(tmr[a])) begin
                            fault = inrush_fault_i[a]
                                    || (pair_cfg_i[p].class_high && inrush_fault_i[b]);
                            if (fault) begin
                                next_state[a] = CH_COOL;
                                next_state[b] = CH_COOL;
                                next_tmr[a]   = load(COOL_CYC);
                                next_tmr[b]   = load(COOL_CYC);
                                start_set[a]  = 1'b1;
                                start_set[b]  = 1'b1;
                            end else begin
                                next_state[a] = CH_ON;
                                next_state[b] = CH_ON;
                            end
                        end
                    end
                    CH_ON: begin
                        if (lim_hit[a] || lim_hit[b]) begin
                            next_state[a] = CH_COOL;
                            next_state[b] = CH_COOL;
                            next_tmr[a]   = load(COOL_CYC);
                            next_tmr[b]   = load(COOL_CYC);
                        end
                    end
                    CH_COOL: begin
                        if (timer_done(tmr[a])) begin
                            next_state[a] = CH_OFF;
                            next_state[b] = CH_OFF;
                        end
                    end
                    default: begin
                        next_state[a] = CH_OFF;
                        next_state[b] = CH_OFF;
                    end
                endcase
            end else begin
                for (int c = 2 * p; c <= 2 * p + 1; c++) begin
                    // each channel alone, a fault never touches its neighbour
                    case (state[c])
                        CH_OFF: begin
                            if (power_on_command_i[c]) begin
                                next_state[c] = CH_INRUSH;
                                next_tmr[c]   = load(START_CYC);
                            end
                        end
                        CH_INRUSH: begin
                            if (timer_done(tmr[c])) begin
                                if (inrush_fault_i[c]) begin
                                    next_state[c] = CH_COOL;
                                    next_tmr[c]   = load(COOL_CYC);
                                    start_set[c]  = 1'b1;
                                end else begin
                                    next_state[c] = CH_ON;
                                end
                            end
                        end
                        CH_ON: begin
                            if (lim_hit[c]) begin
                                next_state[c] = CH_COOL;
                                next_tmr[c]   = load(COOL_CYC);
                            end
                        end
                        CH_COOL: begin
                            if (timer_done(tmr[c])) begin
                                next_state[c] = CH_OFF;
                            end
                        end
                        default: begin
                            next_state[c] = CH_OFF;
                        end
                    endcase
                end
            end
        end
        start_set = start_set | (discovery_error_i & {NUM_CH{!auto_mode_i}});
        for (int p = 0; p < NUM_PAIR; p++) begin
            // a single-signature port is one load: dropping one half drops both,
            // otherwise the odd channel stays on with nothing left to sequence it
            if (pair_cfg_i[p].four_pair && !pair_cfg_i[p].dual_sig
                && (power_off_i[2 * p] || power_off_i[2 * p + 1])) begin
                next_state[2 * p]     = CH_OFF;
                next_state[2 * p + 1] = CH_OFF;
                next_tmr[2 * p]       = 32'h0000_0000;
                next_tmr[2 * p + 1]   = 32'h0000_0000;
            end
        end
        for (int c = 0; c < NUM_CH; c++) begin
            // a host off command or thermal shutdown overrides any sequence
            if (power_off_i[c] || supply_evt_i.thermal_shutdown_flag) begin
                next_state[c] = CH_OFF;
                next_tmr[c]   = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (srst_i) begin
                state[c] <= CH_OFF;
            end else begin
                state[c] <= next_state[c];
            end
        end
    end

    // every entry into inrush or cool-down reloads the timer, so reset only has to park it at zero
    always_ff @(posedge clk_i) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (srst_i) begin
                tmr[c] <= 32'h0000_0000;
            end else begin
                tmr[c] <= next_tmr[c];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (srst_i) begin
                channel_enable_o[c] <= 1'b0;
            end else begin
                channel_enable_o[c] <= (next_state[c] == CH_ON) || (next_state[c] == CH_INRUSH);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (srst_i) begin
                power_good_flag_o[c] <= 1'b0;
            end else begin
                power_good_flag_o[c] <= (next_state[c] == CH_ON);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (srst_i) begin
                cooldown_o[c] <= 1'b0;
            end else begin
                cooldown_o[c] <= (next_state[c] == CH_COOL);
            end
        end
    end

    // a new event in the clearing cycle survives: set wins over clear
    always_comb begin
        next_start_limit = start_limit;
        if (clr_start_limit) begin
            next_start_limit = 8'h00;
        end
        next_start_limit[LIM_LSB +: NUM_CH]  = next_start_limit[LIM_LSB +: NUM_CH] & ~power_off_i;
        next_start_limit[STRT_LSB +: NUM_CH] = next_start_limit[STRT_LSB +: NUM_CH] & ~power_off_i;
        next_start_limit[LIM_LSB +: NUM_CH]  = next_start_limit[LIM_LSB +: NUM_CH] | lim_set;
        next_start_limit[STRT_LSB +: NUM_CH] = next_start_limit[STRT_LSB +: NUM_CH] | start_set;
    end

    always_comb begin
        next_supply_fault = clr_supply_fault ? 8'h00 : supply_fault;
        next_supply_fault = next_supply_fault | supply_evt_i;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            start_limit <= START_LIMIT_RESET;
        end else begin
            start_limit <= next_start_limit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            supply_fault <= SUPPLY_FAULT_RESET;
        end else begin
            supply_fault <= next_supply_fault;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= cmd_valid_i;
        end
    end

    // read answer carries the value before the clear takes effect
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rd_data_o <= 8'h00;
        end else if (cmd_valid_i) begin
            case (cmd_code_i)
                CMD_START_LIMIT_RO,
                CMD_START_LIMIT_CLR:  rd_data_o <= start_limit;
                CMD_SUPPLY_FAULT_RO,
                CMD_SUPPLY_FAULT_CLR: rd_data_o <= supply_fault;
                default:              rd_data_o <= UNMAPPED_DATA;
            endcase
        end
    end

    // built from next values so the release lands with the clear itself
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            int_n_o <= 1'b1;
        end else begin
            int_n_o <= !((int_mask_i[0] && |next_start_limit)
                         || (int_mask_i[1] && |next_supply_fault));
        end
    end

endmodule

`default_nettype wire

/* File: verif/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic       clk_i,
    input  wire logic       rd_valid_i,
    input  wire logic [7:0] rd_data_i,
    output logic            cmd_valid_o,
    output logic [7:0]      cmd_code_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o = 8'h00;
    end
    // the code is inverted once released so a stale value never looks valid
    task automatic read(input logic [7:0] code, output logic [7:0] data, output logic ok);
        @(negedge clk_i);
        cmd_valid_o = 1'b1;
        cmd_code_o = code;
        @(negedge clk_i);
        ok = rd_valid_i;
        data = rd_data_i;
        cmd_valid_o = 1'b0;
        cmd_code_o = ~code;
    endtask
endmodule
`default_nettype wire

/* File: verif/pse_event_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module pse_event_asserts
    import pse_event_pkg::*;
#(
    parameter int unsigned COOL_CYC = COOLDOWN_CYC
) (
    input wire logic                      clk_i,
    input wire logic                      srst_i,
    input wire logic                      cmd_valid_i,
    input wire logic [7:0]                cmd_code_i,
    input wire logic [7:0]                rd_data_o,
    input wire logic                      rd_valid_o,
    input wire logic [1:0]                int_mask_i,
    input wire logic                      int_n_o,
    input wire pair_cfg_s [NUM_PAIR-1:0]  pair_cfg_i,
    input wire logic                      auto_mode_i,
    input wire logic [NUM_CH-1:0]         power_on_command_i,
    input wire logic [NUM_CH-1:0]         power_off_i,
    input wire logic [NUM_CH-1:0]         inrush_fault_i,
    input wire logic [NUM_CH-1:0]         current_limit_i,
    input wire logic [NUM_CH-1:0]         discovery_error_i,
    input wire supply_evt_s               supply_evt_i,
    input wire logic [NUM_CH-1:0]         channel_enable_o,
    input wire logic [NUM_CH-1:0]         power_good_flag_o,
    input wire logic [NUM_CH-1:0]         cooldown_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // no start/limit flag can be set while all channels are idle and no error pulses
    wire logic quiet = discovery_error_i == 4'h0 && channel_enable_o == 4'h0;
    logic [7:0] cnt;
    always_ff @(posedge clk_i) begin
        if (srst_i || !cooldown_o[0]) cnt <= 8'h00;
        else cnt <= cnt + 8'h01;
    end
    property p_rd; cmd_valid_i |=> rd_valid_o; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_nord; !cmd_valid_i |=> !rd_valid_o; endproperty
    a_nord: assert property (p_nord) else $error("answer without read");
    property p_clr;
        (cmd_valid_i && cmd_code_i == CMD_START_LIMIT_CLR && quiet) ##1 quiet
        ##1 (cmd_valid_i && cmd_code_i == CMD_START_LIMIT_RO && quiet) |=> rd_data_o == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("start limit not cleared");
    property p_sclr;
        (cmd_valid_i && cmd_code_i == CMD_SUPPLY_FAULT_CLR && supply_evt_i == 8'h00)
        ##1 supply_evt_i == 8'h00 ##1 (cmd_valid_i && cmd_code_i == CMD_SUPPLY_FAULT_RO
        && supply_evt_i == 8'h00) |=> rd_data_o == 8'h00;
    endproperty
    a_sclr: assert property (p_sclr) else $error("supply not cleared");
    property p_irq_rel;
        int_mask_i == 2'b01 && cmd_valid_i && cmd_code_i == CMD_START_LIMIT_CLR && quiet
        |=> int_n_o;
    endproperty
    a_irq_rel: assert property (p_irq_rel) else $error("interrupt held");
    property p_irq_set;
        (int_mask_i == 2'b10 && supply_evt_i != 8'h00 && !cmd_valid_i)
        ##1 (int_mask_i == 2'b10 && !cmd_valid_i) |=> !int_n_o;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("interrupt missing");
    property p_tsd;
        supply_evt_i[SUP_THERMAL] |=> channel_enable_o == 4'h0 && power_good_flag_o == 4'h0;
    endproperty
    a_tsd: assert property (p_tsd) else $error("channels on after thermal");
    property p_off; power_off_i != 4'h0 |=> (channel_enable_o & $past(power_off_i)) == 4'h0;
    endproperty
    a_off: assert property (p_off) else $error("channel on after off");
    property p_ss_low;
        power_on_command_i == 4'h1 && pair_cfg_i[0] == 3'b100 && channel_enable_o[1:0] == 2'b00
        && cooldown_o[1:0] == 2'b00 && !supply_evt_i[7] && power_off_i == 4'h0
        |=> channel_enable_o[1:0] == 2'b01;
    endproperty
    a_ss_low: assert property (p_ss_low) else $error("single inrush wrong");
    property p_ss_high;
        power_on_command_i == 4'h4 && pair_cfg_i[1] == 3'b101 && channel_enable_o[3:2] == 2'b00
        && cooldown_o[3:2] == 2'b00 && !supply_evt_i[7] && power_off_i == 4'h0
        |=> channel_enable_o[3:2] == 2'b11;
    endproperty
    a_ss_high: assert property (p_ss_high) else $error("parallel inrush wrong");
    property p_cool;
        $fell(cooldown_o[0]) && !$past(power_off_i[0]) && !$past(supply_evt_i[7])
        |-> 32'(cnt) == COOL_CYC;
    endproperty
    a_cool: assert property (p_cool) else $error("cool-down length wrong");
    c_clr: cover property (cmd_valid_i && cmd_code_i == CMD_START_LIMIT_CLR);
    c_cool: cover property ($rose(cooldown_o[0]));
    c_pg: cover property (power_good_flag_o[1:0] == 2'b11);
endmodule
bind pse_port_fault_event_flags pse_event_asserts #(.COOL_CYC(COOL_CYC)) u_chk (
    .clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .int_mask_i(int_mask_i),
    .int_n_o(int_n_o), .pair_cfg_i(pair_cfg_i), .auto_mode_i(auto_mode_i),
    .power_on_command_i(power_on_command_i), .power_off_i(power_off_i),
    .inrush_fault_i(inrush_fault_i), .current_limit_i(current_limit_i),
    .discovery_error_i(discovery_error_i), .supply_evt_i(supply_evt_i),
    .channel_enable_o(channel_enable_o), .power_good_flag_o(power_good_flag_o),
    .cooldown_o(cooldown_o)
);
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top import pse_event_pkg::*;;
    localparam int S = 8;
    localparam int L = 8;
    localparam int C = 16;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic cmd_valid_i;
    logic [7:0] cmd_code_i;
    logic [7:0] rd_data_o;
    logic rd_valid_o;
    logic int_n_o;
    logic [1:0] int_mask_i = 2'b01;
    pair_cfg_s [NUM_PAIR-1:0] pair_cfg_i = '0;
    logic auto_mode_i = 1'b0;
    logic [3:0] power_on_command_i = 4'h0;
    logic [3:0] power_off_i = 4'h0;
    logic [3:0] inrush_fault_i = 4'h0;
    logic [3:0] current_limit_i = 4'h0;
    logic [3:0] discovery_error_i = 4'h0;
    supply_evt_s supply_evt_i = '0;
    logic [3:0] channel_enable_o;
    logic [3:0] power_good_flag_o;
    logic [3:0] cooldown_o;
    int n_fail = 0;
    int comparisons = 0;
    always #10 clk_i = ~clk_i;
    pse_port_fault_event_flags #(.START_CYC(S), .LIMIT_CYC(L), .COOL_CYC(C)) dut (
        .clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .int_mask_i(int_mask_i),
        .int_n_o(int_n_o), .pair_cfg_i(pair_cfg_i), .auto_mode_i(auto_mode_i),
        .power_on_command_i(power_on_command_i), .power_off_i(power_off_i),
        .inrush_fault_i(inrush_fault_i), .current_limit_i(current_limit_i),
        .discovery_error_i(discovery_error_i), .supply_evt_i(supply_evt_i),
        .channel_enable_o(channel_enable_o), .power_good_flag_o(power_good_flag_o),
        .cooldown_o(cooldown_o));
    host_model host (.clk_i(clk_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
        .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic rd_check(input logic [7:0] code, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host.read(code, d, v);
        chk({7'h00, v}, 8'h01, "read valid");
        chk(d, exp, "read data");
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic pulse_on(input logic [3:0] m);
        power_on_command_i = m;
        cyc(1);
        power_on_command_i = 4'h0;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #50us;
        n_fail++;
        give_verdict();
    end
    initial begin
        cyc(3);
        srst_i = 1'b0;
        cyc(1);
        chk({7'h00, int_n_o}, 8'h01, "int idle");
        rd_check(CMD_START_LIMIT_RO, START_LIMIT_RESET);
        rd_check(CMD_SUPPLY_FAULT_RO, SUPPLY_FAULT_RESET);
        rd_check(8'h3C, 8'h00);
        $display("test reset done");
        int_mask_i = 2'b10;
        rd_check(CMD_SUPPLY_FAULT_CLR, SUPPLY_FAULT_RESET);
        rd_check(CMD_SUPPLY_FAULT_RO, 8'h00);
        for (int i = 0; i < 8; i++) begin
            supply_evt_i = 8'(8'h01 << i);
            cyc(1);
            supply_evt_i = '0;
            rd_check(CMD_SUPPLY_FAULT_RO, 8'(8'h01 << i));
            chk({7'h00, int_n_o}, 8'h00, "int set");
            rd_check(CMD_SUPPLY_FAULT_CLR, 8'(8'h01 << i));
            chk({7'h00, int_n_o}, 8'h01, "int released");
        end
        int_mask_i = 2'b01;
        $display("test supply done");
        discovery_error_i = 4'h4;
        cyc(1);
        discovery_error_i = 4'h0;
        rd_check(CMD_START_LIMIT_RO, 8'h04);
        chk({7'h00, int_n_o}, 8'h00, "int start");
        rd_check(CMD_START_LIMIT_CLR, 8'h04);
        chk({7'h00, int_n_o}, 8'h01, "int cleared");
        rd_check(CMD_START_LIMIT_RO, 8'h00);
        auto_mode_i = 1'b1;
        discovery_error_i = 4'hF;
        cyc(1);
        discovery_error_i = 4'h0;
        rd_check(CMD_START_LIMIT_RO, 8'h00);
        auto_mode_i = 1'b0;
        $display("test discovery done");
        pair_cfg_i = {3'b101, 3'b100};
        pulse_on(4'h1);
        cyc(S + 2);
        chk({4'h0, power_good_flag_o}, 8'h03, "single pg");
        current_limit_i = 4'h1;
        cyc(L + 2);
        current_limit_i = 4'h0;
        rd_check(CMD_START_LIMIT_RO, 8'h10);
        power_off_i = 4'h3;
        cyc(1);
        power_off_i = 4'h0;
        rd_check(CMD_START_LIMIT_RO, 8'h00);
        $display("test single low done");
        inrush_fault_i = 4'h4;
        pulse_on(4'h4);
        chk({4'h0, channel_enable_o}, 8'h0C, "parallel");
        cyc(S + 2);
        chk({4'h0, cooldown_o}, 8'h0C, "cool both");
        rd_check(CMD_START_LIMIT_CLR, 8'h0C);
        chk({7'h00, int_n_o}, 8'h01, "int cleared");
        inrush_fault_i = 4'h0;
        cyc(C + 2);
        $display("test single high done");
        inrush_fault_i = 4'h1;
        pulse_on(4'h1);
        cyc(S + 2);
        inrush_fault_i = 4'h0;
        chk({4'h0, cooldown_o}, 8'h03, "single cool");
        chk({4'h0, channel_enable_o}, 8'h00, "single off");
        rd_check(CMD_START_LIMIT_CLR, 8'h03);
        cyc(C + 2);
        $display("test single fault done");
        pair_cfg_i[0] = 3'b110;
        inrush_fault_i = 4'h1;
        pulse_on(4'h3);
        cyc(S + 2);
        inrush_fault_i = 4'h0;
        chk({4'h0, cooldown_o}, 8'h01, "dual cool");
        chk({4'h0, power_good_flag_o}, 8'h02, "dual pg");
        cyc(C + 2);
        pulse_on(4'h1);
        cyc(S + 2);
        chk({4'h0, power_good_flag_o}, 8'h03, "restored");
        supply_evt_i = 8'h80;
        cyc(1);
        supply_evt_i = '0;
        cyc(1);
        chk({4'h0, channel_enable_o}, 8'h00, "thermal off");
        rd_check(CMD_SUPPLY_FAULT_CLR, 8'h80);
        $display("test dual done");
        give_verdict();
    end
endmodule
`default_nettype wire
